// *** hw/temp_alarm_logic.sv ***
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module temp_alarm_logic
  import temp_alarm_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = ALARM_PULSE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_valid,
  input  wire logic [15:0] conv_result,
  input  wire logic        ara_answer,
  input  wire logic        gen_call_reset,
  output logic             alarm_pin,
  output logic             conv_run
);

  localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin
      $error("PULSE_CYCLES must be 1 to 65535");
    end
  end

  typedef struct packed {
    logic [7:0]    cfg;
    logic [15:0]   upper;
    logic [15:0]   lower;
    logic [15:0]   temp;
    logic [2:0]    fault_cnt;
    logic          alarm;
    logic          expect_hi;
    logic          valid;
    logic          valid_hi;
    logic [PW-1:0] pulse_cnt;
    logic          pin;
    logic          run;
    logic          ready;
    logic          slverr;
    logic [31:0]   rdata;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic                bus_done;
  logic                wr_done;
  logic                rd_done;
  logic                cfg_wr;
  logic                take;
  logic                is_hi;
  logic                is_lo;
  logic                fault;
  logic [2:0]          need;
  logic [2:0]          cnt_new;
  logic                valid_now;
  logic                mode_int;
  logic [7:0]          cfg_new;
  thermostat_mode_type mode_now;

  // bus strobes; a transfer completes on the edge that sees pready high
  assign bus_done = psel & penable & st_r.ready;
  assign wr_done  = bus_done & pwrite & ~st_r.slverr;
  assign rd_done  = bus_done & ~pwrite;
  assign cfg_wr   = wr_done & (paddr == ADDR_CFG);
  assign cfg_new  = {pwdata[CFG_ONESHOT] & pwdata[CFG_SHUTDOWN], pwdata[6:0]};
  assign mode_now = thermostat_mode_type'(st_r.cfg[CFG_MODE]);
  assign mode_int = (mode_now == MODE_INTERRUPT);

  // a result is taken only while converting: normal mode or pending one-shot
  assign take  = conv_valid & st_r.run;                                 // [R14] [R22]
  assign is_hi = $signed(conv_result) >= $signed(st_r.upper);           // [R1] [R23]
  assign is_lo = $signed(conv_result) <= $signed(st_r.lower);           // [R1] [R23]
  assign fault = is_hi | is_lo;

  // queue depth decode and saturating consecutive-fault count
  always_comb begin
    unique case (st_r.cfg[CFG_QUEUE_HI:CFG_QUEUE_LO])                   // [R2] [R26]
      2'b00: need = QUEUE_1;
      2'b01: need = QUEUE_2;
      2'b10: need = QUEUE_4;
      2'b11: need = QUEUE_6;
    endcase
  end

  assign cnt_new   = (st_r.fault_cnt >= need) ? need : 3'(st_r.fault_cnt + 3'h1); // [R26]
  assign valid_now = fault & (cnt_new >= need);                         // [R3]

  // next-state logic; clears other than general call reset are applied first so a same-cycle set wins
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ready = psel & penable & ~st_r.ready;

    // read data and error are captured while the access phase waits
    if (psel & penable & ~st_r.ready) begin
      st_nxt.slverr = 1'b0;
      st_nxt.rdata  = 32'h0000_0000;
      unique case (paddr)
        ADDR_TEMP:   st_nxt.rdata = {16'h0000, st_r.temp};
        ADDR_CFG:    st_nxt.rdata = {24'h00_0000, st_r.cfg};
        ADDR_LOWER:  st_nxt.rdata = {16'h0000, st_r.lower};
        ADDR_UPPER:  st_nxt.rdata = {16'h0000, st_r.upper};
        ADDR_STATUS: st_nxt.rdata = {26'h000_0000, st_r.valid, st_r.fault_cnt,
                                     st_r.expect_hi, st_r.alarm};
        default:     st_nxt.slverr = 1'b1;
      endcase
      if (pwrite && (paddr == ADDR_TEMP || paddr == ADDR_STATUS)) begin
        st_nxt.slverr = 1'b1;                     // read-only registers refuse writes
      end
    end

    // interrupt mode: any register read or an alert-response answer clears
    if ((rd_done | ara_answer) & mode_int) begin                        // [R10] [R13]
      st_nxt.alarm     = 1'b0;
      st_nxt.pulse_cnt = '0;
    end

    // one-shot pulse countdown, alarm drops when it runs out
    if (st_nxt.pulse_cnt != '0) begin                                   // [R20] [R27]
      st_nxt.pulse_cnt = PW'(st_nxt.pulse_cnt - 1'b1);
      if (st_nxt.pulse_cnt == '0) begin
        st_nxt.alarm = 1'b0;
      end
    end

    // register writes; comparator alarm is touched here only by a write that turns on interrupt mode
    if (wr_done) begin                                                  // [R7]
      if (paddr == ADDR_LOWER) begin
        st_nxt.lower = pwdata[15:0];
      end
      if (paddr == ADDR_UPPER) begin
        st_nxt.upper = pwdata[15:0];
      end
    end
    if (cfg_wr) begin
      st_nxt.cfg = cfg_new;                                             // [R14] [R18] [R25]
      // comparator to interrupt: active alarm stays, next event is the low one
      if (!st_r.cfg[CFG_MODE] && cfg_new[CFG_MODE]) begin               // [R13]
        st_nxt.expect_hi = ~st_nxt.alarm;
      end
      // interrupt to comparator leaves the alarm as it is           [R8]
      if (cfg_new[CFG_MODE]) begin
        if (cfg_new[CFG_SHUTDOWN] && !st_r.cfg[CFG_SHUTDOWN]) begin
          st_nxt.alarm     = 1'b0;                                      // [R15]
          st_nxt.pulse_cnt = '0;
        end
        // shutdown exit: a pending fault of the expected kind fires now
        if (!cfg_new[CFG_SHUTDOWN] && st_r.cfg[CFG_SHUTDOWN] && st_r.valid &&
            (st_r.valid_hi == st_nxt.expect_hi) && !st_nxt.alarm) begin // [R17]
          st_nxt.alarm     = 1'b1;
          st_nxt.expect_hi = ~st_nxt.expect_hi;
        end
      end
    end

    // conversion result: store, count, and act on a valid fault
    if (take) begin
      st_nxt.temp      = conv_result;                                   // [R22]
      st_nxt.fault_cnt = fault ? cnt_new : 3'h0;                        // [R3] [R4]
      st_nxt.valid     = valid_now;
      st_nxt.valid_hi  = is_hi;
      if (st_r.cfg[CFG_SHUTDOWN]) begin
        st_nxt.cfg[CFG_ONESHOT] = 1'b0;                                 // [R18] [R27]
      end
      if (valid_now) begin
        if (!st_nxt.cfg[CFG_MODE]) begin
          st_nxt.alarm = is_hi;                                         // [R5] [R6] [R19]
        end else if (!st_nxt.alarm && (is_hi == st_nxt.expect_hi)) begin // [R11] [R12]
          st_nxt.alarm     = 1'b1;                                      // [R10]
          st_nxt.expect_hi = ~st_nxt.expect_hi;
          if (st_r.cfg[CFG_SHUTDOWN]) begin
            st_nxt.pulse_cnt = PW'(PULSE_CYCLES);                       // [R20] [R27]
          end
        end
      end
    end

    // general call reset wins over everything else
    if (gen_call_reset) begin                                           // [R9]
      st_nxt.cfg       = CFG_RESET;
      st_nxt.alarm     = 1'b0;
      st_nxt.fault_cnt = 3'h0;                                          // [R16]
      st_nxt.expect_hi = 1'b1;
      st_nxt.valid     = 1'b0;
      st_nxt.valid_hi  = 1'b0;
      st_nxt.pulse_cnt = '0;
    end

    // pin polarity and converter run request, both registered
    st_nxt.pin = st_nxt.cfg[CFG_POLARITY] ? st_nxt.alarm : ~st_nxt.alarm; // [R24]
    st_nxt.run = ~st_nxt.cfg[CFG_SHUTDOWN] | st_nxt.cfg[CFG_ONESHOT];    // [R14] [R18]
  end

  // single state register; reset selects comparator and idle alarm
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.cfg       <= CFG_RESET;                                      // [R25]
      st_r.upper     <= UPPER_RESET;
      st_r.lower     <= LOWER_RESET;
      st_r.expect_hi <= 1'b1;                                           // [R12]
      st_r.pin       <= 1'b1;
      st_r.run       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata    = st_r.rdata;
  assign pready    = st_r.ready;
  assign pslverr   = st_r.slverr;
  assign alarm_pin = st_r.pin;
  assign conv_run  = st_r.run;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = ~gen_call_reset & ~wr_done;

  sequence s_pulse_start;
    take & valid_now & is_hi & mode_int & st_r.cfg[CFG_SHUTDOWN] & ~st_r.alarm
      & st_r.expect_hi & quiet & ~rd_done & ~ara_answer;
  endsequence

  sequence s_pulse_hold;
    st_r.alarm & (st_r.pulse_cnt == PW'(PULSE_CYCLES));
  endsequence

  a_pulse_starts: assert property (s_pulse_start |=> s_pulse_hold) // [R20]
    else $error("one-shot pulse did not start");

  a_pulse_ends: assert property ((st_r.pulse_cnt == PW'(1)) & ~take & quiet
    |=> ~st_r.alarm && st_r.pulse_cnt == '0) // [R27]
    else $error("one-shot pulse did not end");

  a_count_clear: assert property (take & ~fault & ~gen_call_reset
    |=> st_r.fault_cnt == 3'h0) // [R4]
    else $error("fault counter not cleared");

  a_cmp_high_set: assert property (take & valid_now & is_hi & ~mode_int & quiet
    |=> st_r.alarm ##0 st_r.pin == st_r.cfg[CFG_POLARITY]) // [R5]
    else $error("comparator alarm not set");

  a_cmp_low_clear: assert property (take & valid_now & ~is_hi & ~mode_int & quiet
    |=> ~st_r.alarm) // [R6]
    else $error("comparator alarm not cleared");

  a_int_read_clear: assert property (mode_int & rd_done & ~take & ~gen_call_reset
    |=> ~st_r.alarm) // [R10]
    else $error("interrupt alarm not cleared by read");

  a_int_first_high: assert property (take & valid_now & ~is_hi & mode_int
    & st_r.expect_hi & ~st_r.alarm & quiet |=> ~st_r.alarm) // [R12]
    else $error("low event asserted alarm out of turn");

  a_gcr_defaults: assert property (gen_call_reset
    |=> ~st_r.alarm && st_r.cfg == CFG_RESET && st_r.fault_cnt == 3'h0) // [R9]
    else $error("general call reset left state");

  a_shutdown_hold: assert property (st_r.cfg[CFG_SHUTDOWN] & ~take & ~gen_call_reset
    |=> $stable(st_r.fault_cnt)) // [R16]
    else $error("fault count changed in shutdown");

  a_oneshot_clear: assert property (take & st_r.cfg[CFG_SHUTDOWN] & quiet
    |=> ~st_r.cfg[CFG_ONESHOT] ##1 ~st_r.run) // [R18]
    else $error("one-shot bit not cleared");

  a_pin_level: assert property (st_r.pin == (st_r.cfg[CFG_POLARITY] ~^ st_r.alarm)) // [R24]
    else $error("alarm pin level wrong");

  // the alarm hold checks below exclude a reset or a pending pulse in the same cycle,
  // since either may legally move the alarm whatever else is going on

  // comparator alarm ignores writes, unless the write also turns on interrupt mode
  a_cmp_write_keep: assert property (wr_done & ~mode_int & ~take // [R7]
    & ~gen_call_reset & (st_r.pulse_cnt == '0) & ~(cfg_wr & pwdata[CFG_MODE])
    |=> $stable(st_r.alarm))
    else $error("comparator alarm moved on a write");

  // comparator alarm ignores reads
  a_cmp_read_keep: assert property (rd_done & ~mode_int & ~take // [R7]
    & ~gen_call_reset & (st_r.pulse_cnt == '0)
    |=> $stable(st_r.alarm))
    else $error("comparator alarm moved on a read");

  // an alert-response answer clears an interrupt alarm
  a_int_ara_clear: assert property (ara_answer & mode_int & ~take & quiet // [R10]
    |=> ~st_r.alarm)
    else $error("interrupt alarm not cleared by answer");

  // an upper event of the expected kind raises the interrupt alarm
  a_int_set_high: assert property (take & valid_now & is_hi & mode_int // [R10]
    & ~st_r.alarm & st_r.expect_hi & quiet
    |=> st_r.alarm && ~st_r.expect_hi)
    else $error("interrupt alarm not raised");

  // an event out of turn leaves an idle interrupt alarm idle
  a_int_out_turn: assert property (take & valid_now & mode_int & ~st_r.alarm // [R11]
    & (is_hi != st_r.expect_hi) & quiet
    |=> ~st_r.alarm)
    else $error("interrupt alarm raised out of turn");

  // shutdown entry clears the alarm in interrupt mode
  a_sd_int_clear: assert property (cfg_wr & pwdata[CFG_SHUTDOWN] // [R15]
    & pwdata[CFG_MODE] & ~st_r.cfg[CFG_SHUTDOWN] & ~take & ~gen_call_reset
    |=> ~st_r.alarm)
    else $error("shutdown entry kept interrupt alarm");

  // shutdown entry keeps the alarm in comparator mode
  a_sd_cmp_keep: assert property (cfg_wr & pwdata[CFG_SHUTDOWN] // [R15]
    & ~pwdata[CFG_MODE] & ~mode_int & ~take & ~gen_call_reset
    & (st_r.pulse_cnt == '0)
    |=> $stable(st_r.alarm))
    else $error("shutdown entry moved comparator alarm");

  // interrupt to comparator switch keeps an active alarm
  a_int_to_cmp_hold: assert property (cfg_wr & mode_int & ~pwdata[CFG_MODE] // [R8]
    & st_r.alarm & (st_r.pulse_cnt == '0) & ~take & ~gen_call_reset & ~ara_answer
    |=> st_r.alarm)
    else $error("alarm lost on switch to comparator");

  // comparator to interrupt switch keeps an active alarm; the low event is next
  a_cmp_to_int_hold: assert property (cfg_wr & ~mode_int & pwdata[CFG_MODE] // [R13]
    & ~pwdata[CFG_SHUTDOWN] & st_r.alarm & (st_r.pulse_cnt == '0) & ~take
    & ~gen_call_reset
    |=> st_r.alarm && ~st_r.expect_hi)
    else $error("alarm lost on switch to interrupt");

  // leaving shutdown fires a pending fault of the expected kind
  a_sd_exit_fire: assert property (cfg_wr & mode_int & pwdata[CFG_MODE] // [R17]
    & ~pwdata[CFG_SHUTDOWN] & st_r.cfg[CFG_SHUTDOWN] & st_r.valid
    & (st_r.valid_hi == st_r.expect_hi) & ~st_r.alarm & ~take & ~gen_call_reset
    |=> st_r.alarm)
    else $error("pending fault not fired on shutdown exit");

  // each fault below the queue depth steps the counter by one
  a_count_step: assert property (take & fault & (st_r.fault_cnt < need) // [R3]
    & ~gen_call_reset
    |=> st_r.fault_cnt == 3'($past(st_r.fault_cnt) + 3'h1))
    else $error("fault counter did not step");

  // the counter saturates at the queue depth
  a_count_sat: assert property (take & fault & (st_r.fault_cnt >= need) // [R26]
    & ~gen_call_reset
    |=> st_r.fault_cnt == $past(need))
    else $error("fault counter did not saturate");

  // a queue depth of one makes every fault valid
  a_queue_one: assert property (take & fault // [R2]
    & (st_r.cfg[CFG_QUEUE_HI:CFG_QUEUE_LO] == 2'b00)
    |-> valid_now)
    else $error("single fault not valid");

  // no result is stored while shut down without a one-shot request
  a_sd_no_conv: assert property (st_r.cfg[CFG_SHUTDOWN] // [R14]
    & ~st_r.cfg[CFG_ONESHOT]
    |=> $stable(st_r.temp))
    else $error("result stored in shutdown");

  // a lower one-shot fault in comparator mode clears the alarm
  a_os_cmp_low: assert property (take & valid_now & ~is_hi & ~mode_int // [R19]
    & st_r.cfg[CFG_SHUTDOWN] & quiet
    |=> ~st_r.alarm)
    else $error("one-shot low fault kept alarm");

  // general call reset returns to comparator mode with an active-low pin
  a_gcr_mode: assert property (gen_call_reset // [R25]
    |=> mode_now == MODE_COMPARATOR && st_r.pin)
    else $error("reset did not select comparator");

endmodule

// *** hw/temp_alarm_pkg.sv ***
// What this block does
// (R1) fault when result >= upper or <= lower
// (R2) two-bit queue picks 1, 2, 4, 6 faults
// (R3) count faults; reaching setting gives valid fault
// (R4) non-fault result clears fault counter
// (R5) comparator: upper valid fault sets alarm
// (R6) comparator: lower valid fault clears alarm
// (R7) comparator: reads, writes, shutdown keep alarm
// (R8) interrupt to comparator keeps active alarm
// (R9) general call reset clears alarm, config
// (R10) interrupt: upper fault sets; read/ack/shutdown clear
// (R11) interrupt: alarms alternate upper then lower
// (R12) interrupt: first alarm must be upper
// (R13) comparator to interrupt keeps alarm until cleared
// (R14) shutdown bit stops conversions, bus stays alive
// (R15) shutdown entry clears alarm in interrupt mode
// (R16) fault counter kept across shutdown
// (R17) shutdown exit asserts expected pending fault
// (R18) one-shot bit runs one conversion in shutdown
// (R19) comparator one-shot sets or clears alarm
// (R20) interrupt one-shot fault pulses alarm briefly
// (R21) host keeps upper limit above lower limit
// (R22) normal mode converts and stores continuously
// (R23) each stored result checked against both limits
// (R24) alarm pin active low unless polarity bit
// (R25) reset selects comparator; mode bit selects
// (R26) queue codes 00/01/10/11; counter saturates
// (R27) one-shot pulse fixed cycles; bit self-clears
package temp_alarm_pkg;
  // register indices and their byte addresses on the bus
  localparam int unsigned REG_IDX_TEMP   = 0;
  localparam int unsigned REG_IDX_CFG    = 1;
  localparam int unsigned REG_IDX_LOWER  = 2;
  localparam int unsigned REG_IDX_UPPER  = 3;
  localparam int unsigned REG_IDX_STATUS = 4;
  localparam logic [7:0]  ADDR_TEMP      = 8'(REG_IDX_TEMP * 4);
  localparam logic [7:0]  ADDR_CFG       = 8'(REG_IDX_CFG * 4);
  localparam logic [7:0]  ADDR_LOWER     = 8'(REG_IDX_LOWER * 4);
  localparam logic [7:0]  ADDR_UPPER     = 8'(REG_IDX_UPPER * 4);
  localparam logic [7:0]  ADDR_STATUS    = 8'(REG_IDX_STATUS * 4);
  // configuration field positions
  localparam int unsigned CFG_SHUTDOWN   = 0;
  localparam int unsigned CFG_MODE       = 1;
  localparam int unsigned CFG_POLARITY   = 2;
  localparam int unsigned CFG_QUEUE_LO   = 3;
  localparam int unsigned CFG_QUEUE_HI   = 4;
  localparam int unsigned CFG_ONESHOT    = 7;
  // status field positions
  localparam int unsigned ST_ALARM       = 0;
  localparam int unsigned ST_EXPECT_HI   = 1;
  localparam int unsigned ST_CNT_LSB     = 2;
  localparam int unsigned ST_VALID       = 5;
  // reset values
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [15:0] LOWER_RESET    = 16'h4b00;
  localparam logic [15:0] UPPER_RESET    = 16'h5000;
  // queue depths per code
  localparam logic [2:0]  QUEUE_1        = 3'h1;
  localparam logic [2:0]  QUEUE_2        = 3'h2;
  localparam logic [2:0]  QUEUE_4        = 3'h4;
  localparam logic [2:0]  QUEUE_6        = 3'h6;
  // one-shot alarm pulse length in mclk cycles
  localparam int unsigned ALARM_PULSE_CYCLES = 16;
  typedef enum logic {
    MODE_COMPARATOR = 1'b0,
    MODE_INTERRUPT  = 1'b1
  } thermostat_mode_type;
endpackage

// *** testbench/sensor_source.sv ***
`timescale 1ns/1ns
// converter stand-in: one result strobe per request while runs are allowed
module sensor_source (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] value,
  input  wire logic        conv_run,
  output logic             conv_valid,
  output logic [15:0]      conv_result
);
  // result bus scrambles outside the strobe so a stale value is never mistaken for data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_valid  <= 1'b0;
      conv_result <= 16'h0000;
    end else begin
      conv_valid  <= start && conv_run;
      conv_result <= (start && conv_run) ? value : ~conv_result;
    end
  end
endmodule

// *** testbench/temperature_alarm_logic_tb_top.sv ***
`timescale 1ns/1ns
module temperature_alarm_logic_tb_top
  import temp_alarm_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  logic        ara_answer = 1'b0, gen_call_reset = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, wd, rnd = 32'habb0;
  logic [15:0] value = 16'h0, conv_result, up_m = UPPER_RESET, lo_m = LOWER_RESET;
  logic        pready, pslverr, conv_valid, alarm_pin, conv_run, err;
  // expected alarm state kept by the bench
  logic [15:0] temp_m = 16'h0;
  logic [7:0]  cfg_m = CFG_RESET;
  logic [2:0]  cnt_m = 3'h0;
  logic        alarm_m = 1'b0, exp_hi_m = 1'b1, last_v = 1'b0, last_hi = 1'b0;
  int          failures = 0, total_checks = 0, cycles = 0;

  temp_alarm_logic #(.PULSE_CYCLES(2)) temp_alarm_logic_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv_result(conv_result), .ara_answer(ara_answer),
    .gen_call_reset(gen_call_reset), .alarm_pin(alarm_pin), .conv_run(conv_run));
  sensor_source sensor_source_inst (.mclk(mclk), .rst(rst), .start(start), .value(value),
    .conv_run(conv_run), .conv_valid(conv_valid), .conv_result(conv_result));

  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [2:0] depth(input logic [1:0] q);
    return (q == 2'h0) ? QUEUE_1 : (q == 2'h1) ? QUEUE_2 : (q == 2'h2) ? QUEUE_4 : QUEUE_6;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a inside {ADDR_TEMP, ADDR_CFG, ADDR_LOWER, ADDR_UPPER, ADDR_STATUS};
  endfunction

  task automatic check_value(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // pin level follows the alarm through the polarity bit
  task automatic settle();
    @(posedge mclk);
    #1 check_value("alarm_pin", cfg_m[CFG_POLARITY] ? alarm_m : !alarm_m, alarm_pin);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // pready seen high ends this wait; if it never comes, the bench timeout does
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    check_value("write pslverr", !(a inside {ADDR_CFG, ADDR_LOWER, ADDR_UPPER}), err);
    if (a == ADDR_LOWER) lo_m = d[15:0];
    if (a == ADDR_UPPER) up_m = d[15:0];
    if (a == ADDR_CFG) begin
      if (d[CFG_MODE] && !cfg_m[CFG_MODE]) exp_hi_m = !alarm_m;
      if (cfg_m[CFG_MODE] && d[CFG_SHUTDOWN] && !cfg_m[CFG_SHUTDOWN]) alarm_m = 1'b0;
      if (cfg_m[CFG_MODE] && cfg_m[CFG_SHUTDOWN] && !d[CFG_SHUTDOWN] && last_v
          && last_hi == exp_hi_m && !alarm_m) begin
        alarm_m = 1'b1;
        exp_hi_m = !last_hi;
      end
      cfg_m = {d[7] & d[0], d[6:0]};
    end
    settle();
  endtask

  task automatic rdreg(input logic [7:0] a);
    logic [31:0] e;
    e = (a == ADDR_TEMP) ? {16'h0, temp_m} : (a == ADDR_CFG) ? {24'h0, cfg_m} :
        (a == ADDR_LOWER) ? {16'h0, lo_m} : {16'h0, up_m};
    apb(1'b0, a, 32'h0);
    check_value("read pslverr", !mapped(a), err);
    if (a == ADDR_STATUS) begin
      check_value("status alarm", alarm_m, rd[ST_ALARM]);
      check_value("status count", cnt_m, rd[ST_VALID-1:ST_CNT_LSB]);
      check_value("status expect", exp_hi_m, rd[ST_EXPECT_HI]);
    end else if (mapped(a)) check_value("prdata", e, rd);
    // every completed read clears an interrupt alarm, refused address too
    if (cfg_m[CFG_MODE]) alarm_m = 1'b0;
    settle();
  endtask

  task automatic pulse(input logic g);
    @(posedge mclk);
    gen_call_reset <= g;
    ara_answer <= !g;
    @(posedge mclk);
    gen_call_reset <= 1'b0;
    ara_answer <= 1'b0;
    if (cfg_m[CFG_MODE] || g) alarm_m = 1'b0;
    if (g) {cfg_m, cnt_m, exp_hi_m, last_v} = {CFG_RESET, 3'h0, 1'b1, 1'b0};
    settle();
  endtask

  // one conversion through the converter stand-in, then the expected alarm
  task automatic conv(input logic [15:0] t);
    logic       hi, f, p;
    logic [2:0] d;
    p = 1'b0;
    hi = $signed(t) >= $signed(up_m);
    f = hi || $signed(t) <= $signed(lo_m);
    d = depth(cfg_m[CFG_QUEUE_HI:CFG_QUEUE_LO]);
    @(posedge mclk);
    start <= 1'b1;
    value <= t;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    if (!cfg_m[CFG_SHUTDOWN] || cfg_m[CFG_ONESHOT]) begin
      cfg_m[CFG_ONESHOT] = 1'b0;
      temp_m = t;
      cnt_m = f ? ((cnt_m >= d) ? d : cnt_m + 3'h1) : 3'h0;
      last_v = f && cnt_m >= d;
      last_hi = hi;
      if (last_v && !cfg_m[CFG_MODE]) alarm_m = hi;
      if (last_v && cfg_m[CFG_MODE] && !alarm_m && hi == exp_hi_m) begin
        alarm_m = 1'b1;
        exp_hi_m = !hi;
        p = cfg_m[CFG_SHUTDOWN];
      end
    end
    settle();
    // a one-shot interrupt alarm is a short pulse: seen once, then gone
    if (p) begin
      alarm_m = 1'b0;
      settle();
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 check_value("alarm_pin", 1'b1, alarm_pin);
    for (int a = 0; a < 6; a++) rdreg(8'(a * 4));
    wr(ADDR_TEMP, 32'h1234);
    $display("test reset done");
    // each queue code: one short of depth, a break, depth, then lower depth while shut down
    for (int q = 0; q < 4; q++) begin
      wr(ADDR_CFG, 32'(q << CFG_QUEUE_LO));
      repeat (depth(2'(q)) - 1) conv(up_m);
      conv(16'h4c00);
      repeat (depth(2'(q))) conv(up_m);
      wr(ADDR_CFG, 32'(q << CFG_QUEUE_LO) | 32'h1);
      repeat (depth(2'(q))) conv(lo_m);
      wr(ADDR_CFG, 32'(q << CFG_QUEUE_LO));
    end
    wr(ADDR_CFG, 32'h81);
    conv(up_m);
    rdreg(ADDR_CFG);
    conv(up_m);
    pulse(1'b1);
    wr(ADDR_CFG, 32'h02);
    conv(lo_m);
    conv(up_m);
    rdreg(ADDR_TEMP);
    conv(up_m);
    conv(lo_m);
    pulse(1'b0);
    conv(up_m);
    wr(ADDR_CFG, 32'h03);
    wr(ADDR_CFG, 32'h06);
    pulse(1'b1);
    wr(ADDR_CFG, 32'h87);
    conv(up_m);
    wr(ADDR_CFG, 32'h06);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      rnd = lfsr(rnd);
      case (rnd[2:0])
        3'h3: rdreg({3'h0, rnd[10:8], 2'h0});
        3'h4: pulse(rnd[9:5] == 5'h0);
        3'h5: begin
          wd = {27'h0, rnd[15:11]};
          if (wd[CFG_MODE] != cfg_m[CFG_MODE]) wd[CFG_SHUTDOWN] = cfg_m[CFG_SHUTDOWN];
          wd[CFG_ONESHOT] = !wd[CFG_MODE] && wd[CFG_SHUTDOWN] && rnd[16];
          wr(ADDR_CFG, wd);
        end
        3'h6: begin
          wr(ADDR_LOWER, {16'h0, 8'h48, rnd[25:18]});
          wr(ADDR_UPPER, {16'h0, 8'h49, rnd[31:24]});
        end
        default: conv(lo_m - 16'h0100 + 16'(rnd[31:21]));
      endcase
    end
    $display("test random done");
    results();
  end
endmodule
